//--- rtl/manchester_serial_transmitter.v
// coded serial transmitter: registers, baud generator, shifter, pin driver
`timescale 1ns/10ps
`include "coder_map.vh"
module manchester_serial_transmitter #(
  parameter DATA_W = 8
) (
  // clock and reset
  input wire sys_clk_i,
  input wire sys_rst_i,
  // register access
  input wire [15:0] reg_addr_i,
  input wire reg_wr_i,
  input wire [7:0] reg_wdata_i,
  input wire reg_rd_i,
  output wire [7:0] reg_rdata_o,
  // serial pin and events
  output wire coded_serial_out_o,
  output wire tx_start_irq_o,
  output wire buffer_ready_o
);
  localparam ST_IDLE = 1'b0;
  localparam ST_RUN = 1'b1;

  reg [7:0] tx_data_buffer_reg;
  reg [2:0] tx_bit_count_reg;
  reg [7:0] coder_ctrl_a_reg;
  reg [2:0] coder_ctrl_b_reg;
  reg [4:0] coder_ctrl_c_reg;
  reg [7:0] rdata_reg;
  reg state_reg;
  reg [7:0] shift_reg;
  reg [2:0] bit_idx_reg;
  reg [2:0] bits_left_reg;
  reg half_reg;
  reg [4:0] pre_reg;
  reg [4:0] div_reg;
  reg out_reg;
  reg irq_reg;
  reg [7:0] rdata_next;
  reg out_next;

  wire op_enable;
  wire first_bit_order;
  wire code_select;
  wire idle_level;
  wire wr_tx;
  wire buf_in_ready;
  wire buf_out_valid;
  wire buf_out_ready;
  wire [10:0] buf_out_data;
  wire base_en;
  wire [4:0] div_k;
  wire tick;
  wire frame_end;
  wire load;
  wire cur_bit;
  wire [7:0] status;

  // base clock enable: every 2^sel cycles, reserved codes use the slowest
  function base_enable;
    input [2:0] sel;
    input [4:0] pre;
    reg [2:0] s;
    reg [4:0] mask;
    begin
      s = (sel > `BASE_SEL_MAX) ? `BASE_SEL_MAX : sel;
      mask = ~(5'h1F << s);
      base_enable = ((pre & mask) == mask);
    end
  endfunction

  // start index of a frame: low bits only for short frames
  function [2:0] start_idx;
    input lsb_first;
    input [2:0] cnt;
    begin
      start_idx = lsb_first ? 3'h0 : cnt;
    end
  endfunction

  assign op_enable = coder_ctrl_a_reg[`POS_OP_ENABLE];
  assign first_bit_order = coder_ctrl_a_reg[`POS_FIRST_BIT];
  assign code_select = coder_ctrl_a_reg[`POS_CODE_SEL];
  assign idle_level = coder_ctrl_a_reg[`POS_IDLE_LEVEL];
  assign wr_tx = reg_wr_i & (reg_addr_i == `ADDR_TX_DATA);

  // count is captured with the byte, so a later count write waits its turn
  tx_pair_buffer #(
    .WIDTH(11)
  ) u_buf (
    .sys_clk_i(sys_clk_i),
    .sys_rst_i(sys_rst_i),
    .flush_i(~op_enable),
    .in_valid_i(wr_tx & op_enable),
    .in_ready_o(buf_in_ready),
    .in_data_i({tx_bit_count_reg, reg_wdata_i}),
    .out_valid_o(buf_out_valid),
    .out_ready_i(buf_out_ready),
    .out_data_o(buf_out_data)
  );

  // divider codes below four act as four
  assign div_k = (coder_ctrl_c_reg < `DIV_MIN) ? `DIV_MIN : coder_ctrl_c_reg;
  assign base_en = base_enable(coder_ctrl_b_reg, pre_reg);
  // one tick per half bit: baud is tick rate over two
  assign tick = (state_reg == ST_RUN) & base_en & (div_reg == div_k - 5'h01);
  assign frame_end = tick & half_reg & (bits_left_reg == 3'h0);
  assign buf_out_ready = op_enable & ((state_reg == ST_IDLE) | frame_end);
  assign load = buf_out_valid & buf_out_ready;
  assign cur_bit = shift_reg[bit_idx_reg];

  assign status = {(state_reg == ST_RUN), ~buf_in_ready, 6'h00};
  assign buffer_ready_o = buf_in_ready;
  assign coded_serial_out_o = out_reg;
  assign tx_start_irq_o = irq_reg;
  assign reg_rdata_o = rdata_reg;

  always @* begin
    rdata_next = 8'h00;
    case (reg_addr_i)
      `ADDR_STATUS: rdata_next = status;
      `ADDR_TX_DATA: rdata_next = tx_data_buffer_reg;
      `ADDR_BIT_COUNT: rdata_next = {5'h00, tx_bit_count_reg};
      `ADDR_CTRL_A: rdata_next = coder_ctrl_a_reg;
      `ADDR_CTRL_B: rdata_next = {5'h00, coder_ctrl_b_reg};
      `ADDR_CTRL_C: rdata_next = {3'h0, coder_ctrl_c_reg};
      default: rdata_next = 8'h00;
    endcase
  end

  // software registers
  always @(posedge sys_clk_i or posedge sys_rst_i) begin
    if (sys_rst_i) begin
      tx_data_buffer_reg <= `RST_TX_DATA;
      tx_bit_count_reg <= `RST_BIT_COUNT;
      coder_ctrl_a_reg <= `RST_CTRL_A;
      coder_ctrl_b_reg <= `RST_CTRL_B;
      coder_ctrl_c_reg <= `RST_CTRL_C;
      rdata_reg <= 8'h00;
    end else begin
      if (reg_rd_i)
        rdata_reg <= rdata_next;
      if (reg_wr_i) begin
        case (reg_addr_i)
          `ADDR_TX_DATA: tx_data_buffer_reg <= reg_wdata_i;
          `ADDR_BIT_COUNT: tx_bit_count_reg <= reg_wdata_i[2:0];
          `ADDR_CTRL_A: coder_ctrl_a_reg <= reg_wdata_i & `MASK_CTRL_A;
          `ADDR_CTRL_B: coder_ctrl_b_reg <= reg_wdata_i[2:0];
          `ADDR_CTRL_C: coder_ctrl_c_reg <= reg_wdata_i[4:0];
          default: tx_data_buffer_reg <= tx_data_buffer_reg;
        endcase
      end
    end
  end

  // pin level: manchester halves or plain bit, inverted by level select
  always @* begin
    out_next = idle_level;
    if (~op_enable) begin
      // abort drops the pin to idle at the very next edge
      out_next = idle_level;
    end else if (load) begin
      if (code_select)
        out_next = buf_out_data[start_idx(first_bit_order, buf_out_data[10:8])];
      else
        out_next = buf_out_data[start_idx(first_bit_order, buf_out_data[10:8])];
      out_next = out_next ^ idle_level;
    end else if (state_reg == ST_RUN) begin
      if (tick & ~half_reg & ~code_select)
        out_next = ~cur_bit ^ idle_level;
      else if (tick & half_reg)
        out_next = idle_level;
      else
        out_next = out_reg;
      if (tick & half_reg & (bits_left_reg != 3'h0)) begin
        if (first_bit_order)
          out_next = shift_reg[bit_idx_reg + 3'h1] ^ idle_level;
        else
          out_next = shift_reg[bit_idx_reg - 3'h1] ^ idle_level;
      end
    end
  end

  // shifter and baud generator
  always @(posedge sys_clk_i or posedge sys_rst_i) begin
    if (sys_rst_i) begin
      state_reg <= ST_IDLE;
      shift_reg <= 8'h00;
      bit_idx_reg <= 3'h0;
      bits_left_reg <= 3'h0;
      half_reg <= 1'b0;
      pre_reg <= 5'h00;
      div_reg <= 5'h00;
      out_reg <= 1'b0;
      irq_reg <= 1'b0;
    end else begin
      irq_reg <= load;
      out_reg <= out_next;
      if (~op_enable) begin
        // held still so nothing toggles while stopped
        state_reg <= ST_IDLE;
        half_reg <= 1'b0;
        pre_reg <= 5'h00;
        div_reg <= 5'h00;
      end else if (load) begin
        state_reg <= ST_RUN;
        shift_reg <= buf_out_data[7:0];
        bits_left_reg <= buf_out_data[10:8];
        bit_idx_reg <= start_idx(first_bit_order, buf_out_data[10:8]);
        half_reg <= 1'b0;
        pre_reg <= 5'h00;
        div_reg <= 5'h00;
      end else if (state_reg == ST_RUN) begin
        pre_reg <= pre_reg + 5'h01;
        if (base_en)
          div_reg <= tick ? 5'h00 : div_reg + 5'h01;
        if (tick) begin
          half_reg <= ~half_reg;
          if (half_reg) begin
            if (bits_left_reg == 3'h0) begin
              state_reg <= ST_IDLE;
            end else begin
              bits_left_reg <= bits_left_reg - 3'h1;
              bit_idx_reg <= first_bit_order ? bit_idx_reg + 3'h1 : bit_idx_reg - 3'h1;
            end
          end
        end
      end
    end
  end
endmodule

//--- rtl/coder_map.vh
// register map, reset values and field positions of the coded serial transmitter
// Behaviour
// - stopped mode keeps output and logic idle
// - Manchester mode sends each bit coded
// - sequential mode sends plain level per bit
// - first bit order and output level selectable
// - buffer write starts only when enabled
// - byte moves into shift register, shifts out
// - control bit 1 selects coding
// - transmit buffer resets to all ones
// - bit count plus one gives frame length
// - bit count resets to seven
// - start interrupt; next count after it
// - short frames send low-order bits only
// - prescaler select then 5-bit divider
// - baud is divider rate over two
// - divider codes below four divide by four
// - status cleared by reset and disable
`ifndef CODER_MAP_VH
`define CODER_MAP_VH
`define ADDR_STATUS 16'hFF47
`define ADDR_TX_DATA 16'hFF4A
`define ADDR_BIT_COUNT 16'hFF4B
`define ADDR_CTRL_A 16'hFF4C
`define ADDR_CTRL_B 16'hFF4D
`define ADDR_CTRL_C 16'hFF4E
`define RST_TX_DATA 8'hFF
`define RST_BIT_COUNT 3'h7
`define RST_CTRL_A 8'h10
`define RST_CTRL_B 3'h0
`define RST_CTRL_C 5'h1F
`define MASK_CTRL_A 8'h93
`define POS_OP_ENABLE 7
`define POS_FIRST_BIT 4
`define POS_CODE_SEL 1
`define POS_IDLE_LEVEL 0
`define POS_ST_BUSY 7
`define POS_ST_FULL 6
`define BASE_SEL_MAX 3'h5
`define DIV_MIN 5'h04
`endif

//--- rtl/tx_pair_buffer.v
// two-entry valid/ready buffer, output word from a register
`timescale 1ns/10ps
module tx_pair_buffer #(
  parameter WIDTH = 11
) (
  // clock and reset
  input wire sys_clk_i,
  input wire sys_rst_i,
  input wire flush_i,
  // filling side
  input wire in_valid_i,
  output wire in_ready_o,
  input wire [WIDTH-1:0] in_data_i,
  // draining side
  output wire out_valid_o,
  input wire out_ready_i,
  output wire [WIDTH-1:0] out_data_o
);
  reg [WIDTH-1:0] head_reg;
  reg [WIDTH-1:0] tail_reg;
  reg [1:0] fill_reg;
  wire push;
  wire pop;

  assign in_ready_o = (fill_reg != 2'h2);
  assign out_valid_o = (fill_reg != 2'h0);
  assign out_data_o = head_reg;
  assign push = in_valid_i & in_ready_o;
  assign pop = out_valid_o & out_ready_i;

  always @(posedge sys_clk_i or posedge sys_rst_i) begin
    if (sys_rst_i) begin
      head_reg <= {WIDTH{1'b0}};
      tail_reg <= {WIDTH{1'b0}};
      fill_reg <= 2'h0;
    end else if (flush_i) begin
      fill_reg <= 2'h0;
    end else begin
      case ({push, pop})
        2'b10: begin
          if (fill_reg == 2'h0)
            head_reg <= in_data_i;
          else
            tail_reg <= in_data_i;
          fill_reg <= fill_reg + 2'h1;
        end
        2'b01: begin
          head_reg <= tail_reg;
          fill_reg <= fill_reg - 2'h1;
        end
        2'b11: begin
          // full cannot push, so fill is 1 here
          head_reg <= in_data_i;
        end
        default: begin
          fill_reg <= fill_reg;
        end
      endcase
    end
  end
endmodule

//--- testbench/mst_sva.sv
// port assertions for the coded serial transmitter
`timescale 1ns/10ps
module mst_sva (
  input wire sys_clk_i,
  input wire sys_rst_i,
  input wire [15:0] reg_addr_i,
  input wire reg_wr_i,
  input wire [7:0] reg_wdata_i,
  input wire reg_rd_i,
  input wire [7:0] reg_rdata_o,
  input wire coded_serial_out_o,
  input wire tx_start_irq_o,
  input wire buffer_ready_o
);
  reg [7:0] ca_reg;
  reg en_q_reg;
  reg sel0_reg;
  reg klo_reg;
  reg [3:0] pend_reg;
  wire pin = coded_serial_out_o;
  wire irq = tx_start_irq_o;
  wire w = reg_wr_i;
  wire ld = w && ca_reg[7] && buffer_ready_o && reg_addr_i == 16'hFF4A;
  wire stop = !ca_reg[7] && !en_q_reg;
  wire h4 = sel0_reg && klo_reg;
  default clocking @(posedge sys_clk_i); endclocking
  default disable iff (sys_rst_i);
  // shadow of the control fields, words accepted minus frames started
  always @(posedge sys_clk_i or posedge sys_rst_i) begin
    if (sys_rst_i) begin
      ca_reg <= 8'h10;
      en_q_reg <= 1'b0;
      sel0_reg <= 1'b1;
      klo_reg <= 1'b0;
      pend_reg <= 4'h0;
    end else begin
      en_q_reg <= ca_reg[7];
      if (w && reg_addr_i == 16'hFF4C) ca_reg <= reg_wdata_i;
      if (w && reg_addr_i == 16'hFF4D) sel0_reg <= reg_wdata_i[2:0] == 3'h0;
      if (w && reg_addr_i == 16'hFF4E) klo_reg <= reg_wdata_i[4:0] <= 5'h04;
      if (w && reg_addr_i == 16'hFF4C && !reg_wdata_i[7]) pend_reg <= 4'h0;
      else pend_reg <= pend_reg + {3'h0, ld} - {3'h0, irq};
    end
  end
  // half bit of four cycles: three more stable samples
  sequence s_half;
    $stable(pin)[*3];
  endsequence
  sequence s_bit;
    $stable(pin)[*7];
  endsequence
  AST_IRQ_ONE: assert property (irq |=> !irq)
    else $error("start pulse too long");
  AST_IRQ_WR: assert property (irq |-> pend_reg != 4'h0)
    else $error("start without data");
  AST_STOP_IRQ: assert property (stop |-> !irq)
    else $error("start while stopped");
  AST_STOP_PIN: assert property (stop && $stable(ca_reg) |-> pin == ca_reg[0])
    else $error("pin not idle");
  AST_ST_CLR: assert property (stop && reg_rd_i && reg_addr_i == 16'hFF47
    |=> reg_rdata_o == 8'h00) else $error("status not clear");
  AST_CNT_W: assert property (reg_rd_i && reg_addr_i == 16'hFF4B
    |=> reg_rdata_o[7:3] == 5'h00) else $error("count too wide");
  AST_MAN_MID: assert property (irq && !ca_reg[1] && h4
    |=> s_half ##1 pin != $past(pin)) else $error("no mid transition");
  AST_SEQ_BIT: assert property (irq && ca_reg[1] && h4 |=> s_bit)
    else $error("bit not held");
endmodule
bind manchester_serial_transmitter mst_sva u_mst_sva (.sys_clk_i(sys_clk_i),
  .sys_rst_i(sys_rst_i), .reg_addr_i(reg_addr_i), .reg_wr_i(reg_wr_i),
  .reg_wdata_i(reg_wdata_i), .reg_rd_i(reg_rd_i), .reg_rdata_o(reg_rdata_o),
  .coded_serial_out_o(coded_serial_out_o), .tx_start_irq_o(tx_start_irq_o),
  .buffer_ready_o(buffer_ready_o));

//--- testbench/line_rx.sv
// remote receiver model sampling each half bit of the line
`timescale 1ns/10ps
module line_rx #(
  parameter H = 4
) (
  input wire clk_i,
  input wire start_i,
  input wire line_i,
  output reg [15:0] halves_o
);
  integer c = 0;
  initial halves_o = 16'h0000;
  // one sample per half bit; restarts on every start pulse
  always @(posedge clk_i) begin
    if (start_i || (c > 0 && c < 16 * H)) begin
      c <= start_i ? 1 : c + 1;
      if (start_i || c % H == 0) halves_o <= {halves_o[14:0], line_i};
    end
  end
endmodule

//--- testbench/tb_top.sv
// self-checking bench for the coded serial transmitter
`timescale 1ns/10ps
module tb_top;
  reg sys_clk_i = 1'b0;
  reg sys_rst_i = 1'b1;
  reg [15:0] ad = 16'h0000;
  reg wr = 1'b0;
  reg rd = 1'b0;
  reg [7:0] wd = 8'h00;
  wire [7:0] rdat;
  wire pin;
  wire irq;
  wire rdy;
  wire [15:0] hv;
  reg [15:0] e;
  reg [2:0] cur = 3'h7;
  integer n_fail = 0;
  integer check_count = 0;
  integer nirq = 0;
  integer i;
  integer j;
  manchester_serial_transmitter u_manchester_serial_transmitter (.sys_clk_i(sys_clk_i),
    .sys_rst_i(sys_rst_i), .reg_addr_i(ad), .reg_wr_i(wr), .reg_wdata_i(wd), .reg_rd_i(rd),
    .reg_rdata_o(rdat), .coded_serial_out_o(pin), .tx_start_irq_o(irq), .buffer_ready_o(rdy));
  line_rx u_line_rx (.clk_i(sys_clk_i), .start_i(irq), .line_i(pin), .halves_o(hv));
  initial forever #5 sys_clk_i = ~sys_clk_i;
  always @(posedge sys_clk_i) if (irq === 1'b1) nirq <= nirq + 1;
  task chk(input [15:0] s, input [15:0] x);
    begin
      check_count = check_count + 1;
      if (s !== x) begin
        n_fail = n_fail + 1;
        $display("[ERR] %0t seen %h exp %h", $time, s, x);
      end
    end
  endtask
  task end_sim;
    begin
      $display("checks %0d failures %0d", check_count, n_fail);
      if (n_fail == 0 && check_count > 0) $display("Test passed");
      else $display("Test failed");
      $finish;
    end
  endtask
  task cyc(input integer n);
    repeat (n) @(posedge sys_clk_i) #1;
  endtask
  task wreg(input [15:0] a, input [7:0] d);
    begin
      cyc(1);
      ad = a;
      wd = d;
      wr = 1'b1;
      cyc(1);
      wr = 1'b0;
    end
  endtask
  task rchk(input [15:0] a, input [7:0] x);
    begin
      cyc(1);
      ad = a;
      rd = 1'b1;
      cyc(1);
      rd = 1'b0;
      chk({8'h00, rdat}, {8'h00, x});
    end
  endtask
  task wirq;
    begin
      i = 0;
      while (irq !== 1'b1 && i < 300) begin
        cyc(1);
        i = i + 1;
      end
      if (i == 300) begin
        n_fail = n_fail + 1;
        end_sim;
      end
    end
  endtask
  // one frame, then compare the receiver's half-bit samples
  task frame(input [7:0] c, input [2:0] n, input [7:0] d, input [7:0] k);
    begin
      wreg(16'hFF4C, 8'h00);
      wreg(16'hFF4E, k);
      wreg(16'hFF4C, c);
      if (n !== cur) wreg(16'hFF4B, {5'h00, n});
      cur = n;
      wreg(16'hFF4A, d);
      wirq;
      cyc(70);
      for (i = 0; i < 8; i = i + 1) begin
        e[15 - 2 * i] = i > n ? c[0] : c[0] ^ (c[4] ? d[i] : d[n - i]);
        e[14 - 2 * i] = i > n ? c[0] : e[15 - 2 * i] ^ !c[1];
      end
      chk(hv, e);
    end
  endtask
  // base clock of two cycles, k=4: one sequential bit is 16 cycles
  task t_base;
    begin
      wreg(16'hFF4C, 8'h00);
      wreg(16'hFF4D, 8'h01);
      wreg(16'hFF4E, 8'h04);
      wreg(16'hFF4C, 8'h82);
      wreg(16'hFF4B, 8'h00);
      wreg(16'hFF4A, 8'h01);
      wirq;
      j = 0;
      while (pin === 1'b1 && j < 100) begin
        cyc(1);
        j = j + 1;
      end
      chk(j, 16);
      wreg(16'hFF4C, 8'h00);
      wreg(16'hFF4D, 8'h00);
      wreg(16'hFF4B, 8'h07);
      cur = 3'h7;
    end
  endtask
  task t_stop;
    begin
      wreg(16'hFF4C, 8'h01);
      wreg(16'hFF4A, 8'h5A);
      for (i = 0; i < 40; i = i + 1) begin
        chk({irq, pin}, 2'b01);
        cyc(1);
      end
      rchk(16'hFF47, 8'h00);
    end
  endtask
  // disable in mid frame: slow baud keeps the first half long
  task t_abort;
    begin
      wreg(16'hFF4E, 8'h1F);
      wreg(16'hFF4C, 8'h80);
      wreg(16'hFF4A, 8'h80);
      wirq;
      rchk(16'hFF47, 8'h80);
      wreg(16'hFF4C, 8'h00);
      rchk(16'hFF47, 8'h00);
      chk(pin, 1'b0);
    end
  endtask
  task t_stream;
    begin
      wreg(16'hFF4E, 8'h04);
      wreg(16'hFF4C, 8'h90);
      i = nirq;
      wreg(16'hFF4A, 8'h11);
      wreg(16'hFF4A, 8'h22);
      wreg(16'hFF4A, 8'h33);
      chk(rdy, 1'b0);
      rchk(16'hFF47, 8'hC0);
      cyc(220);
      chk(nirq - i, 3);
      chk(rdy, 1'b1);
    end
  endtask
  initial begin
    cyc(12);
    sys_rst_i = 1'b0;
    rchk(16'hFF4A, 8'hFF);
    rchk(16'hFF4B, 8'h07);
    rchk(16'hFF47, 8'h00);
    rchk(16'hFF40, 8'h00);
    t_stop;
    frame(8'h80, 3'h7, 8'hA5, 8'h04);
    frame(8'h93, 3'h2, 8'hC6, 8'h02);
    frame(8'h81, 3'h2, 8'hC6, 8'h04);
    frame(8'h92, 3'h2, 8'h5B, 8'h04);
    frame(8'h90, 3'h0, 8'h01, 8'h04);
    frame(8'h82, 3'h7, 8'h3C, 8'h04);
    t_base;
    t_abort;
    t_stream;
    end_sim;
  end
endmodule
